// ===== hdl/cad_classify.sv
// combinational opcode classifier: mode, byte counts, index select
// assumes opcode and prefix are held stable by the sequencer
`timescale 1ns/1ps
module cad_classify (
   cad_dec_if.cls bus
);
   import cad_pkg::*;
   cad_mode_t base;
   logic [3:0] grp;
   assign grp = bus.opcode[7:4];
   ////////////////////////////////////////////////////////////////
   // base mode from opcode group
   // group decode
   always_comb begin
      unique case (grp)
         G_BIT_REL: base = M_BIT_DR;
         G_BIT: base = M_BIT_D;
         G_REL: base = M_REL_D;
         G_RMW_DIR, G_SDIR: base = M_SDIR;
         G_RMW_SIDX, G_SIDX: base = M_SIDX;
         G_RMW_IDX0, G_IDX0: base = M_IDX0;
         G_IMM: base = M_IMM;
         G_LDIR: base = M_LDIR;
         G_LIDX: base = M_LIDX;
         default: base = M_INH;
      endcase
   end
   // memory groups hold no long form
   assign bus.rmw = (grp == G_BIT_REL) || (grp == G_BIT) || (grp == G_RMW_DIR)
      || (grp == G_RMW_SIDX) || (grp == G_RMW_IDX0);
   ////////////////////////////////////////////////////////////////
   // prebyte remapping
   // prebyte remap
   always_comb begin
      bus.mode = base;
      bus.index_y = 1'b0;
      bus.illegal = 1'b0;
      if (bus.prefix == PRE_IND) begin
         unique case (base)
            M_BIT_DR: bus.mode = M_BIT_IR;
            M_BIT_D: bus.mode = M_BIT_I;
            M_REL_D: bus.mode = M_REL_I;
            M_SDIR: bus.mode = M_SIND;
            M_LDIR: bus.mode = (bus.rmw) ? M_SIND : M_LIND;
            M_SIDX: bus.mode = M_SIND_IDX;
            M_LIDX: bus.mode = (bus.rmw) ? M_SIND_IDX : M_LIND_IDX;
            default: bus.illegal = 1'b1;
         endcase
      end else if (bus.prefix == PRE_YIND) begin
         bus.index_y = 1'b1;
         if (base == M_SIDX) bus.mode = M_SIND_IDX;
         else if (base == M_LIDX) bus.mode = M_LIND_IDX;
         else bus.illegal = 1'b1;
      end else if (bus.prefix == PRE_Y) begin
         bus.index_y = 1'b1;
         bus.illegal = (base == M_BIT_DR) || (base == M_BIT_D) || (base == M_REL_D);
      end
   end
   ////////////////////////////////////////////////////////////////
   // byte counts after the opcode and pointer size
   // byte counts
   always_comb begin
      unique case (bus.mode)
         M_INH, M_IDX0: bus.opnd_len = 2'h0;
         M_LDIR, M_LIDX, M_BIT_DR, M_BIT_IR: bus.opnd_len = 2'h2;
         default: bus.opnd_len = 2'h1;
      endcase
   end
   always_comb begin
      unique case (bus.mode)
         M_SIND, M_SIND_IDX, M_REL_I, M_BIT_I, M_BIT_IR: bus.ptr_len = 2'h1;
         M_LIND, M_LIND_IDX: bus.ptr_len = 2'h2;
         default: bus.ptr_len = 2'h0;
      endcase
   end
endmodule

// ===== hdl/cad_dec_if.sv
// opcode classification signals between sequencer and classifier
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
interface cad_dec_if;
   import cad_pkg::*;
   logic [7:0] opcode;
   logic [7:0] prefix;
   cad_mode_t mode;
   logic [1:0] opnd_len;
   logic [1:0] ptr_len;
   logic index_y;
   logic rmw;
   logic illegal;
   modport cls (input opcode, prefix,
      output mode, opnd_len, ptr_len, index_y, rmw, illegal);
   modport seq (output opcode, prefix,
      input mode, opnd_len, ptr_len, index_y, rmw, illegal);
endinterface

// ===== hdl/cad_decoder.sv
// instruction fetch and effective-address decoder
// assumes memory answers a held read with mem_ready, index values
// are stable while an instruction decodes, and pc_load redirects
`timescale 1ns/1ps
module cad_decoder #(
   parameter int ADDR_W = 16
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic pc_load,
   input wire logic [15:0] pc_value,
   input wire logic [7:0] x_idx,
   input wire logic [7:0] y_idx,
   input wire logic irq_req,
   output logic mem_rd,
   output logic [15:0] mem_addr,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_ready,
   output logic dec_valid,
   output logic dec_illegal,
   output cad_pkg::cad_mode_t dec_mode,
   output logic [7:0] dec_opcode,
   output logic dec_index_y,
   output logic dec_rmw,
   output logic [15:0] dec_pc,
   output logic [15:0] dec_next_pc,
   output logic [15:0] dec_ea,
   output logic [7:0] dec_imm,
   output logic [15:0] dec_target,
   output logic [1:0] irq_mask,
   output logic cpu_wait,
   output logic osc_stop
);
   import cad_pkg::*;

   if (ADDR_W != 16) begin : g_bad_width
      $error("cad_decoder supports a 16-bit address only");
   end

   cad_dec_if dif ();
   cad_state_t state;
   logic [15:0] pc;
   logic [15:0] op_pc;
   logic [7:0] prefix_r;
   logic [7:0] opcode_r;
   logic [7:0] b1;
   logic [7:0] b2;
   logic [7:0] p1;
   logic [7:0] p2;
   logic opnd_cnt;
   logic ptr_cnt;

   cad_classify u_cls (
      .bus(dif.cls)
   );

   assign dif.opcode = opcode_r;
   assign dif.prefix = prefix_r;

   ////////////////////////////////////////////////////////////////
   // bus handshake and byte classification
   wire logic take;
   wire logic is_prefix;
   wire logic last_opnd;
   wire logic last_ptr;
   wire logic [7:0] ptr_loc;
   assign mem_rd = (state == ST_OP) || (state == ST_OPND) || (state == ST_PTR);
   assign take = mem_rd && mem_ready;
   assign is_prefix = (prefix_r == NO_PREFIX) && ((mem_rdata == PRE_Y)
      || (mem_rdata == PRE_YIND) || (mem_rdata == PRE_IND));
   assign last_opnd = (opnd_cnt == (dif.opnd_len == 2'h2));
   assign last_ptr = (ptr_cnt == (dif.ptr_len == 2'h2));
   assign ptr_loc = (opnd_cnt == 1'b0) ? mem_rdata : b1;

   ////////////////////////////////////////////////////////////////
   // effective address and branch target
   wire logic long_dir;
   wire logic indexed;
   wire logic via_ptr;
   wire logic [7:0] idx;
   wire logic [15:0] dir16;
   wire logic [15:0] ptr16;
   wire logic [15:0] base16;
   wire logic [15:0] ea_w;
   wire logic [7:0] rel_off;
   wire logic [15:0] target_w;
   // long direct uses the full word
   assign long_dir = (dif.mode == M_LDIR) || (dif.mode == M_LIDX);
   // short forms stay in page zero
   assign dir16 = long_dir ? {b1, b2} : {PAGE_ZERO_HI, b1};
   assign ptr16 = (dif.ptr_len == 2'h2) ? {p1, p2} : {PAGE_ZERO_HI, p1};
   assign via_ptr = (dif.ptr_len != 2'h0) && (dif.mode != M_REL_I);
   assign base16 = (dif.mode == M_IDX0) ? 16'h0000 : (via_ptr ? ptr16 : dir16);
   assign idx = dif.index_y ? y_idx : x_idx;
   assign indexed = (dif.mode == M_IDX0) || (dif.mode == M_SIDX)
      || (dif.mode == M_LIDX) || (dif.mode == M_SIND_IDX) || (dif.mode == M_LIND_IDX);
   // unsigned add, short form tops at 1FE
   assign ea_w = base16 + (indexed ? {8'h00, idx} : 16'h0000);
   assign rel_off = ((dif.mode == M_BIT_DR) || (dif.mode == M_BIT_IR)) ? b2
      : ((dif.mode == M_REL_I) ? p1 : b1);
   // signed offset from the next instruction
   assign target_w = pc + {{8{rel_off[7]}}, rel_off};

   ////////////////////////////////////////////////////////////////
   // fetch sequencer
   cad_state_t next_state;
   always_comb begin
      next_state = state;
      unique case (state)
         ST_OP: if (take && !is_prefix) next_state = ST_CLASS;
         ST_CLASS: begin
            if (dif.illegal) next_state = ST_DONE;
            // no operand fetch for inherent and zero-offset indexed forms
            else if (dif.opnd_len == 2'h0) next_state = ST_DONE;
            else next_state = ST_OPND;
         end
         ST_OPND: begin
            if (take && last_opnd) begin
               next_state = (dif.ptr_len != 2'h0) ? ST_PTR : ST_DONE;
            end
         end
         ST_PTR: if (take && last_ptr) next_state = ST_DONE;
         ST_DONE: begin
            if (dif.illegal) next_state = ST_OP;
            else if (opcode_r == OP_WFI && prefix_r == NO_PREFIX) next_state = ST_WAIT;
            else if (opcode_r == OP_HALT && prefix_r == NO_PREFIX) next_state = ST_HALT;
            else next_state = ST_OP;
         end
         ST_WAIT, ST_HALT: if (irq_req) next_state = ST_OP;
      endcase
      if (pc_load) next_state = ST_OP;
   end

   // state, program counter and fetch address
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_OP;
         pc <= RESET_PC;
         mem_addr <= RESET_PC;
      end else begin
         state <= next_state;
         if (pc_load) begin
            pc <= pc_value;
            mem_addr <= pc_value;
         end else if (take && state == ST_PTR) begin
            mem_addr <= last_ptr ? pc : mem_addr + 16'h0001;
         end else if (take && state == ST_OPND && last_opnd && dif.ptr_len != 2'h0) begin
            pc <= pc + 16'h0001;
            mem_addr <= {PAGE_ZERO_HI, ptr_loc};
         end else if (take) begin
            pc <= pc + 16'h0001;
            mem_addr <= mem_addr + 16'h0001;
         end
      end
   end

   // captured bytes
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prefix_r <= NO_PREFIX;
         opcode_r <= 8'h00;
         op_pc <= RESET_PC;
         b1 <= 8'h00;
         b2 <= 8'h00;
         p1 <= 8'h00;
         p2 <= 8'h00;
         opnd_cnt <= 1'b0;
         ptr_cnt <= 1'b0;
      end else begin
         if (pc_load || state == ST_DONE) prefix_r <= NO_PREFIX;
         else if (take && state == ST_OP && is_prefix) prefix_r <= mem_rdata;
         if (take && state == ST_OP && !is_prefix) begin
            opcode_r <= mem_rdata;
            op_pc <= pc;
         end
         if (take && state == ST_OPND && !opnd_cnt) b1 <= mem_rdata;
         if (take && state == ST_OPND && opnd_cnt) b2 <= mem_rdata;
         if (take && state == ST_PTR && !ptr_cnt) p1 <= mem_rdata;
         if (take && state == ST_PTR && ptr_cnt) p2 <= mem_rdata;
         // byte counters hold through memory wait states
         if (state != ST_OPND) opnd_cnt <= 1'b0;
         else if (take) opnd_cnt <= !last_opnd;
         if (state != ST_PTR) ptr_cnt <= 1'b0;
         else if (take) ptr_cnt <= !last_ptr;
      end
   end

   ////////////////////////////////////////////////////////////////
   // decoded instruction outputs
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dec_valid <= 1'b0;
         dec_illegal <= 1'b0;
         dec_mode <= M_INH;
         dec_opcode <= 8'h00;
         dec_index_y <= 1'b0;
         dec_rmw <= 1'b0;
         dec_pc <= RESET_PC;
         dec_next_pc <= RESET_PC;
         dec_ea <= 16'h0000;
         dec_imm <= 8'h00;
         dec_target <= 16'h0000;
      end else begin
         dec_valid <= (state == ST_DONE) && !dif.illegal && !pc_load;
         dec_illegal <= (state == ST_DONE) && dif.illegal && !pc_load;
         if (state == ST_DONE) begin
            dec_mode <= dif.mode;
            dec_opcode <= opcode_r;
            dec_index_y <= dif.index_y;
            dec_rmw <= dif.rmw;
            dec_pc <= op_pc;
            dec_next_pc <= pc;
            dec_ea <= ea_w;
            // operand value is the byte after the opcode
            dec_imm <= b1;
            dec_target <= target_w;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // interrupt mask and low-power controls
   wire logic ctrl_done;
   assign ctrl_done = (state == ST_DONE) && (prefix_r == NO_PREFIX) && !pc_load;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask <= MASK_RESET;
      end else if (ctrl_done && opcode_r == OP_MASK_RAISE) begin
         irq_mask <= MASK_HIGH;
      end else if (ctrl_done && opcode_r == OP_MASK_LOWER) begin
         irq_mask <= MASK_LOW;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_wait <= 1'b0;
         osc_stop <= 1'b0;
      end else begin
         cpu_wait <= (next_state == ST_WAIT);
         osc_stop <= (next_state == ST_HALT);
      end
   end

   ////////////////////////////////////////////////////////////////
   // checks
   sequence s_wfi_done;
      ctrl_done && opcode_r == OP_WFI;
   endsequence
   sequence s_asleep;
      cpu_wait && !osc_stop;
   endsequence
   property p_mask_raise;
      @(posedge mclk) disable iff (!rst_n)
      ctrl_done && opcode_r == OP_MASK_RAISE |=> irq_mask == MASK_HIGH;
   endproperty
   a_mask_raise: assert property (p_mask_raise) else $error("mask not raised");
   property p_mask_lower;
      @(posedge mclk) disable iff (!rst_n)
      ctrl_done && opcode_r == OP_MASK_LOWER |=> irq_mask == MASK_LOW;
   endproperty
   a_mask_lower: assert property (p_mask_lower) else $error("mask not lowered");
   property p_wait;
      @(posedge mclk) disable iff (!rst_n)
      s_wfi_done ##1 !irq_req && !pc_load |=> s_asleep ##0 !mem_rd;
   endproperty
   a_wait: assert property (p_wait) else $error("wait state not held");
   property p_halt;
      @(posedge mclk) disable iff (!rst_n)
      ctrl_done && opcode_r == OP_HALT |=> osc_stop && !mem_rd;
   endproperty
   a_halt: assert property (p_halt) else $error("halt not entered");
   property p_inh_len;
      @(posedge mclk) disable iff (!rst_n)
      dec_valid && (dec_mode == M_INH) |-> dec_next_pc == dec_pc + 16'h0001;
   endproperty
   a_inh_len: assert property (p_inh_len) else $error("inherent not one byte");
   property p_imm_len;
      @(posedge mclk) disable iff (!rst_n)
      dec_valid && (dec_mode == M_IMM) |-> dec_next_pc == dec_pc + 16'h0002;
   endproperty
   a_imm_len: assert property (p_imm_len) else $error("immediate not two bytes");
   property p_ldir_len;
      @(posedge mclk) disable iff (!rst_n)
      dec_valid && (dec_mode == M_LDIR) |-> dec_next_pc == dec_pc + 16'h0003;
   endproperty
   a_ldir_len: assert property (p_ldir_len) else $error("long direct length");
   property p_short_page0;
      @(posedge mclk) disable iff (!rst_n)
      dec_valid && (dec_mode == M_SDIR || dec_mode == M_SIND) |-> dec_ea[15:8] == 8'h00;
   endproperty
   a_short_page0: assert property (p_short_page0) else $error("short left page zero");
   property p_sidx_max;
      @(posedge mclk) disable iff (!rst_n)
      dec_valid && (dec_mode == M_SIDX) |-> dec_ea <= SHORT_IDX_MAX;
   endproperty
   a_sidx_max: assert property (p_sidx_max) else $error("short indexed beyond 1FE");
   property p_rel_range;
      @(posedge mclk) disable iff (!rst_n)
      dec_valid && dec_mode == M_REL_D |->
         (dec_target - dec_next_pc + 16'h0080) <= 16'h00FF;
   endproperty
   a_rel_range: assert property (p_rel_range) else $error("branch out of range");
   property p_rmw_short;
      @(posedge mclk) disable iff (!rst_n)
      dec_valid && dec_rmw |-> dec_mode != M_LDIR && dec_mode != M_LIDX
         && dec_mode != M_LIND && dec_mode != M_LIND_IDX;
   endproperty
   a_rmw_short: assert property (p_rmw_short) else $error("long form on memory op");
   property p_fetch_hold;
      @(posedge mclk) disable iff (!rst_n)
      mem_rd && !mem_ready && !pc_load |=> $stable(mem_addr) && mem_rd;
   endproperty
   a_fetch_hold: assert property (p_fetch_hold) else $error("fetch dropped");
endmodule

// ===== hdl/cad_pkg.sv
// constants, mode and state types for the addressing-mode decoder
// assumes a byte-wide memory bus and 8-bit index registers x and y
package cad_pkg;
   // prebytes
   localparam logic [7:0] NO_PREFIX = 8'h00;
   localparam logic [7:0] PRE_Y = 8'h90;
   localparam logic [7:0] PRE_YIND = 8'h91;
   localparam logic [7:0] PRE_IND = 8'h92;
   // inherent control opcodes
   localparam logic [7:0] OP_HALT = 8'h8E;
   localparam logic [7:0] OP_WFI = 8'h8F;
   localparam logic [7:0] OP_MASK_LOWER = 8'h9A;
   localparam logic [7:0] OP_MASK_RAISE = 8'h9B;
   // interrupt mask levels
   localparam logic [1:0] MASK_HIGH = 2'h3;
   localparam logic [1:0] MASK_LOW = 2'h0;
   localparam logic [1:0] MASK_RESET = 2'h3;
   // opcode groups, upper nibble
   localparam logic [3:0] G_BIT_REL = 4'h0;
   localparam logic [3:0] G_BIT = 4'h1;
   localparam logic [3:0] G_REL = 4'h2;
   localparam logic [3:0] G_RMW_DIR = 4'h3;
   localparam logic [3:0] G_RMW_SIDX = 4'h6;
   localparam logic [3:0] G_RMW_IDX0 = 4'h7;
   localparam logic [3:0] G_IMM = 4'hA;
   localparam logic [3:0] G_SDIR = 4'hB;
   localparam logic [3:0] G_LDIR = 4'hC;
   localparam logic [3:0] G_LIDX = 4'hD;
   localparam logic [3:0] G_SIDX = 4'hE;
   localparam logic [3:0] G_IDX0 = 4'hF;
   // address limits
   localparam logic [7:0] PAGE_ZERO_HI = 8'h00;
   localparam logic [15:0] SHORT_IDX_MAX = 16'h01FE;
   localparam logic [15:0] RESET_PC = 16'h0000;
   // the seventeen addressing modes
   typedef enum logic [4:0] {
      M_INH, M_IMM, M_SDIR, M_LDIR, M_IDX0, M_SIDX, M_LIDX,
      M_SIND, M_LIND, M_SIND_IDX, M_LIND_IDX, M_REL_D, M_REL_I,
      M_BIT_D, M_BIT_I, M_BIT_DR, M_BIT_IR
   } cad_mode_t;
   // fetch sequencer states
   typedef enum logic [2:0] {
      ST_OP, ST_CLASS, ST_OPND, ST_PTR, ST_DONE, ST_WAIT, ST_HALT
   } cad_state_t;
endpackage

// ===== sim/cad_decoder_test.sv
// self-checking bench for the addressing-mode decoder
// assumes the memory model answers every held read
`timescale 1ns/1ps
module cad_decoder_test;
   import cad_pkg::*;
   logic mclk, rst_n, pc_load, irq_req, mem_rd, mem_ready;
   logic dec_valid, dec_illegal, dec_index_y, dec_rmw, cpu_wait, osc_stop;
   logic [15:0] pc_value, mem_addr, dec_pc, dec_next_pc, dec_ea, dec_target;
   logic [7:0] x_idx, y_idx, mem_rdata, dec_opcode, dec_imm;
   logic [1:0] irq_mask, stall;
   cad_mode_t dec_mode;
   int mismatches, checked;
   cad_decoder i_dut (.mclk, .rst_n, .pc_load, .pc_value, .x_idx, .y_idx,
      .irq_req, .mem_rd, .mem_addr, .mem_rdata, .mem_ready, .dec_valid,
      .dec_illegal, .dec_mode, .dec_opcode, .dec_index_y, .dec_rmw, .dec_pc,
      .dec_next_pc, .dec_ea, .dec_imm, .dec_target, .irq_mask, .cpu_wait,
      .osc_stop);
   cad_mem_model i_mem (.mclk, .mem_rd, .mem_addr, .mem_rdata, .mem_ready,
      .stall);
   //////////////////////////////////////////////////////////////////////
   // verdict and shared checks
   task automatic tally_and_finish;
      $display("counts: %0d checked, %0d mismatches", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic cv(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic cd(input cad_mode_t m, input logic [15:0] e, input logic [15:0] q);
      cv(16'(dec_mode), 16'(m));
      cv(dec_ea, e);
      cv(dec_next_pc, q);
   endtask
   // wait for the decode of the opcode at p, bounded
   task automatic wait_dec(input logic [15:0] p);
      int n;
      n = 0;
      @(negedge mclk);
      while (!((dec_valid === 1'b1 || dec_illegal === 1'b1) && dec_pc === p)) begin
         n++;
         if (n > 80) begin
            mismatches++;
            $display("[ERR] %0t no decode", $time);
            tally_and_finish();
         end
         @(negedge mclk);
      end
   endtask
   // lay n bytes at a, redirect fetch there and wait for the decode
   task automatic run(input logic [15:0] a, input logic [31:0] b, input int n);
      logic [15:0] p;
      for (int i = 0; i < n; i++) begin
         i_mem.put(a + 16'(i), b[31 - 8 * i -: 8]);
      end
      p = (b[31:24] inside {PRE_Y, PRE_YIND, PRE_IND}) ? a + 16'h0001 : a;
      pc_load = 1'b1;
      pc_value = a;
      @(negedge mclk);
      pc_load = 1'b0;
      wait_dec(p);
   endtask
   //////////////////////////////////////////////////////////////////////
   // one-byte, immediate, direct and memory-modify forms
   task automatic t_basic;
      run(16'h1000, 32'h80000000, 1);
      cd(M_INH, dec_ea, 16'h1001);
      cv(16'(dec_opcode), 16'h0080);
      run(16'h1010, 32'hA6550000, 2);
      cd(M_IMM, dec_ea, 16'h1012);
      cv(16'(dec_imm), 16'h0055);
      run(16'h1020, 32'hB6400000, 2);
      cd(M_SDIR, 16'h0040, 16'h1022);
      cv(16'(dec_rmw), 16'h0000);
      stall <= 2'h2;
      run(16'h1030, 32'hC6123400, 3);
      stall <= 2'h0;
      cd(M_LDIR, 16'h1234, 16'h1033);
      run(16'h1170, 32'h66100000, 2);
      cd(M_SIDX, 16'h010F, 16'h1172);
      cv(16'(dec_rmw), 16'h0001);
      $display("test basic done");
   endtask
   // indexed forms with x at ff and y at 01
   task automatic t_index;
      run(16'h1040, 32'hE6FF0000, 2);
      cd(M_SIDX, 16'h01FE, 16'h1042);
      cv(16'(dec_index_y), 16'h0000);
      run(16'h1050, 32'h90E6FF00, 3);
      cd(M_SIDX, 16'h0100, 16'h1053);
      cv(16'(dec_index_y), 16'h0001);
      cv(16'(dec_opcode), 16'h00E6);
      run(16'h1060, 32'hD6200000, 3);
      cd(M_LIDX, 16'h20FF, 16'h1063);
      run(16'h1070, 32'hF6000000, 1);
      cd(M_IDX0, 16'h00FF, 16'h1071);
      $display("test index done");
   endtask
   // pointer forms through page zero
   task automatic t_indirect;
      run(16'h1080, 32'h92B64000, 3);
      cd(M_SIND, 16'h0077, 16'h1083);
      run(16'h1090, 32'h92C65000, 3);
      cd(M_LIND, 16'h1234, 16'h1093);
      run(16'h10A0, 32'h92E64000, 3);
      cd(M_SIND_IDX, 16'h0176, 16'h10A3);
      run(16'h10B0, 32'h91E64000, 3);
      cd(M_SIND_IDX, 16'h0078, 16'h10B3);
      run(16'h10C0, 32'h92D65000, 3);
      cd(M_LIND_IDX, 16'h1333, 16'h10C3);
      $display("test indirect done");
   endtask
   // branches, bit forms and their targets
   task automatic t_branch;
      run(16'h1100, 32'h27050000, 2);
      cd(M_REL_D, dec_ea, 16'h1102);
      cv(dec_target, 16'h1107);
      run(16'h1110, 32'h27800000, 2);
      cv(dec_target, 16'h1092);
      run(16'h1120, 32'h92276000, 3);
      cd(M_REL_I, 16'h0060, 16'h1123);
      cv(dec_target, 16'h1121);
      run(16'h1130, 32'h16400000, 2);
      cd(M_BIT_D, 16'h0040, 16'h1132);
      run(16'h1140, 32'h06400500, 3);
      cd(M_BIT_DR, 16'h0040, 16'h1143);
      cv(dec_target, 16'h1148);
      run(16'h1150, 32'h92164000, 3);
      cd(M_BIT_I, 16'h0077, 16'h1153);
      run(16'h1160, 32'h92064005, 4);
      cd(M_BIT_IR, 16'h0077, 16'h1164);
      $display("test branch done");
   endtask
   // mask lower then raise, and a refused prebyte pairing
   task automatic t_control;
      run(16'h1200, 32'h9A000000, 1);
      cv(16'(irq_mask), 16'h0000);
      run(16'h1210, 32'h9B000000, 1);
      cv(16'(irq_mask), 16'h0003);
      run(16'h1300, 32'h90260500, 3);
      cv(16'({dec_illegal, dec_valid}), 16'h0002);
      $display("test control done");
   endtask
   // enter wait or halt, stay, wake on interrupt, resume after it
   task automatic t_wake(input logic [7:0] op, input logic [15:0] a);
      run(a, {op, 24'h000000}, 1);
      repeat (3) @(negedge mclk);
      cv(16'({cpu_wait, osc_stop}), op == OP_WFI ? 16'h0002 : 16'h0001);
      irq_req = 1'b1;
      @(negedge mclk);
      irq_req = 1'b0;
      cv(16'({cpu_wait, osc_stop}), 16'h0000);
      wait_dec(a + 16'h0001);
      $display("test wake done");
   endtask
   //////////////////////////////////////////////////////////////////////
   // clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // main sequence
   initial begin
      rst_n = 1'b0;
      pc_load = 1'b0;
      pc_value = 16'h0000;
      x_idx = 8'hFF;
      y_idx = 8'h01;
      irq_req = 1'b0;
      stall = 2'h0;
      mismatches = 0;
      checked = 0;
      // page-zero pointers laid after the model's filler pass
      repeat (2) @(negedge mclk);
      i_mem.put(16'h0040, 8'h77);
      i_mem.put(16'h0050, 8'h12);
      i_mem.put(16'h0051, 8'h34);
      i_mem.put(16'h0060, 8'hFE);
      cv(16'(irq_mask), 16'h0003);
      cv(mem_addr, 16'h0000);
      rst_n = 1'b1;
      t_basic();
      t_index();
      t_indirect();
      t_branch();
      t_control();
      t_wake(OP_WFI, 16'h1400);
      t_wake(OP_HALT, 16'h1500);
      tally_and_finish();
   end
endmodule

// ===== sim/cad_mem_model.sv
// program and data memory model on the cpu bus
// assumes mem_rd and mem_addr settle before the falling edge
`timescale 1ns/1ps
module cad_mem_model (
   input wire logic mclk,
   input wire logic mem_rd,
   input wire logic [15:0] mem_addr,
   output logic [7:0] mem_rdata,
   output logic mem_ready,
   input wire logic [1:0] stall
);
   logic [7:0] mem [0:65535];
   logic [1:0] cnt;
   // lay one byte of code or data
   task automatic put(input logic [15:0] a, input logic [7:0] d);
      mem[a] = d;
   endtask
   // fill with a one-byte filler opcode
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'h9D;
      end
      cnt = 2'h0;
      mem_ready = 1'b0;
      mem_rdata = 8'h00;
   end
   // answer after stall idle cycles, scramble data while not ready
   always @(negedge mclk) begin
      if (mem_rd && cnt == stall) begin
         mem_ready <= 1'b1;
         mem_rdata <= mem[mem_addr];
         cnt <= 2'h0;
      end else begin
         mem_ready <= 1'b0;
         mem_rdata <= ~mem_rdata;
         cnt <= mem_rd ? cnt + 2'h1 : 2'h0;
      end
   end
endmodule
